// [src/port_fgh_alternate_override.sv]
`timescale 1ns/1ps
`default_nettype none

module port_fgh_alternate_override
    import pin_mux_pkg::*;
#(
    parameter bit large_package = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire byte_t f_pin_i,
    output pin_drive_s f_drive,
    output byte_t analog_pin_path,
    input wire byte_t g_pin_i,
    output pin_drive_s g_drive,
    input wire byte_t h_pin_i,
    output pin_drive_s h_drive,
    input wire logic tap_shift_ir,
    input wire logic tap_shift_dr,
    input wire logic tap_serial_out,
    output logic test_clock,
    output logic test_mode_select,
    output logic test_data_in,
    input wire logic reset_pin_disable_fuse,
    output logic external_reset_b,
    output logic timer_zero_count_input,
    output logic timer_one_count_input,
    output byte_t pin_change_source,
    input wire logic [`SEG_COUNT-1:0] segment_drive,
    output logic [4:0] g_segment_output,
    output byte_t h_segment_output
);

    ctrl_s ctrl;
    byte_t f_dir, f_out, g_dir, g_out, h_dir, h_out;
    byte_t f_din, g_din, h_din;
    ovr_s ovr_f [`PORT_WIDTH];
    ovr_s ovr_g [`PORT_WIDTH];
    ovr_s ovr_h [`PORT_WIDTH];
    logic shifting;
    logic test_r, test_nxt;
    logic [2:0] status;
    logic [5:0] g_seg_idx [5];
    logic [4:0] g_seg_r, g_seg_nxt;
    byte_t h_seg_r, h_seg_nxt;

    assign shifting = tap_shift_ir | tap_shift_dr;
    assign status = {reset_pin_disable_fuse, g_din[`G_RESET], shifting};

    port_reg_slave u_regs (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .f_in(f_din),
        .g_in(g_din),
        .h_in(h_din),
        .status(status),
        .ctrl(ctrl),
        .f_dir(f_dir),
        .f_out(f_out),
        .g_dir(g_dir),
        .g_out(g_out),
        .h_dir(h_dir),
        .h_out(h_out)
    );

    // Analog port overrides
    always_comb begin
        for (int i = 0; i < `PORT_WIDTH; i++) begin
            ovr_f[i] = '0;
        end
        for (int i = `F_TCK; i <= `F_TDI; i++) begin
            ovr_f[i].pue = ctrl.test_en;
            ovr_f[i].puv = 1'b1;
            ovr_f[i].dde = ctrl.test_en;
            ovr_f[i].ddv = 1'b0;
            ovr_f[i].diee = ctrl.test_en;
            ovr_f[i].diev = 1'b0;
        end
        ovr_f[`F_TDO].ddv = shifting;
        ovr_f[`F_TDO].pve = ctrl.test_en;
        ovr_f[`F_TDO].pvv = tap_serial_out;
    end

    // Second port overrides
    always_comb begin
        for (int i = 0; i < `PORT_WIDTH; i++) begin
            ovr_g[i] = '0;
        end
        for (int i = 0; i <= `G_T0; i++) begin
            ovr_g[i].pue = ctrl.lcd_en;
            ovr_g[i].dde = ctrl.lcd_en;
            ovr_g[i].diee = ctrl.lcd_en & ctrl.lcd_lp;
        end
        ovr_g[`G_SEG_ONLY].diee = ctrl.lcd_en;
        ovr_g[`G_T0].ddv = 1'b1;
        ovr_g[`G_T0].diee = ctrl.lcd_en & ctrl.lcd_lp;
        ovr_g[`G_RESET].pue = 1'b1;
        ovr_g[`G_RESET].puv = 1'b1;
        ovr_g[`G_RESET].dde = 1'b1;
        ovr_g[`G_RESET].pve = 1'b1;
    end

    // Third port overrides
    always_comb begin
        for (int i = 0; i < `PORT_WIDTH; i++) begin
            ovr_h[i] = '0;
            ovr_h[i].pue = ctrl.lcd_en;
            ovr_h[i].dde = ctrl.lcd_en;
            ovr_h[i].diee = ctrl.lcd_en & ctrl.lcd_lp;
        end
    end

    // Per-pin override resolution
    genvar p;
    generate
        for (p = 0; p < `PORT_WIDTH; p++) begin : g_pin
            pin_override_cell u_f (
                .clk(clk),
                .rst_b(rst_b),
                .ce(ce),
                .ovr(ovr_f[p]),
                .dir_reg(f_dir[p]),
                .out_reg(f_out[p]),
                .pud(ctrl.pud),
                .pin_i(f_pin_i[p]),
                .pin_o(f_drive.o[p]),
                .pin_oe(f_drive.oe[p]),
                .pull_en(f_drive.pull[p]),
                .din(f_din[p])
            );
            pin_override_cell u_g (
                .clk(clk),
                .rst_b(rst_b),
                .ce(ce),
                .ovr(ovr_g[p]),
                .dir_reg(g_dir[p]),
                .out_reg(g_out[p]),
                .pud(ctrl.pud),
                .pin_i(g_pin_i[p]),
                .pin_o(g_drive.o[p]),
                .pin_oe(g_drive.oe[p]),
                .pull_en(g_drive.pull[p]),
                .din(g_din[p])
            );
            if (large_package) begin : g_h
                pin_override_cell u_h (
                    .clk(clk),
                    .rst_b(rst_b),
                    .ce(ce),
                    .ovr(ovr_h[p]),
                    .dir_reg(h_dir[p]),
                    .out_reg(h_out[p]),
                    .pud(ctrl.pud),
                    .pin_i(h_pin_i[p]),
                    .pin_o(h_drive.o[p]),
                    .pin_oe(h_drive.oe[p]),
                    .pull_en(h_drive.pull[p]),
                    .din(h_din[p])
                );
            end else begin : g_no_h
                assign h_drive.o[p] = 1'b0;
                assign h_drive.oe[p] = 1'b0;
                assign h_drive.pull[p] = 1'b0;
                assign h_din[p] = 1'b0;
            end
        end
    endgenerate

    // Segment index per package
    assign g_seg_idx[4] = large_package ? `SEG_G4_L : `SEG_G4_S;
    assign g_seg_idx[3] = large_package ? `SEG_G3_L : `SEG_G3_S;
    assign g_seg_idx[2] = large_package ? `SEG_G2_L : `SEG_G2_S;
    assign g_seg_idx[1] = large_package ? `SEG_G1_L : `SEG_G1_S;
    assign g_seg_idx[0] = large_package ? `SEG_G0_L : `SEG_G0_S;

    // Segment routing and test pin forwarding
    always_comb begin
        g_seg_nxt = '0;
        h_seg_nxt = '0;
        for (int i = 0; i < 5; i++) begin
            g_seg_nxt[i] = ctrl.lcd_en & segment_drive[g_seg_idx[i]];
        end
        for (int i = 0; i < 4; i++) begin
            h_seg_nxt[7-i] = ctrl.lcd_en & segment_drive[`SEG_H_HI + 6'(i)];
            h_seg_nxt[3-i] = ctrl.lcd_en & segment_drive[`SEG_H_LO + 6'(i)];
        end
        if (!large_package) begin
            h_seg_nxt = '0;
        end
        test_nxt = ctrl.test_en;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            g_seg_r <= '0;
            h_seg_r <= '0;
            test_r <= 1'b0;
        end else if (ce) begin
            g_seg_r <= g_seg_nxt;
            h_seg_r <= h_seg_nxt;
            test_r <= test_nxt;
        end
    end

    assign g_segment_output = g_seg_r;
    assign h_segment_output = h_seg_r;

    // Test pins feed the test state machine while enabled, and the analog path at all times
    assign test_clock = test_r & f_pin_i[`F_TCK];
    assign test_mode_select = test_r ? f_pin_i[`F_TMS] : 1'b1;
    assign test_data_in = test_r ? f_pin_i[`F_TDI] : 1'b1;
    assign analog_pin_path = f_pin_i;

    // Reset pin unless the disable fuse is programmed
    assign external_reset_b = reset_pin_disable_fuse ? g_din[`G_RESET] : 1'b1;
    assign timer_zero_count_input = g_din[`G_T0];
    assign timer_one_count_input = g_din[`G_T1];
    assign pin_change_source = h_din;

endmodule : port_fgh_alternate_override

`default_nettype wire

// [src/pin_mux_cfg.svh]
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_F_DIR 8'h04
`define REG_F_OUT 8'h08
`define REG_G_DIR 8'h0c
`define REG_G_OUT 8'h10
`define REG_H_DIR 8'h14
`define REG_H_OUT 8'h18
`define REG_F_IN 8'h1c
`define REG_G_IN 8'h20
`define REG_H_IN 8'h24
`define REG_STAT 8'h28

// Control register fields
`define CTRL_TEST_EN 0
`define CTRL_LCD_EN 1
`define CTRL_LCD_LP 2
`define CTRL_PUD 3
`define CTRL_RST 4'h0

// Status register fields
`define STAT_SHIFT 0
`define STAT_RESET_PIN 1
`define STAT_FUSE 2

// Pin positions
`define F_TCK 4
`define F_TMS 5
`define F_TDO 6
`define F_TDI 7
`define G_RESET 5
`define G_T0 4
`define G_T1 3
`define G_SEG_ONLY 2

// Segment indices: large package, small package
`define SEG_G4_L 6'd32
`define SEG_G4_S 6'd23
`define SEG_G3_L 6'd33
`define SEG_G3_S 6'd24
`define SEG_G2_L 6'd4
`define SEG_G2_S 6'd4
`define SEG_G1_L 6'd17
`define SEG_G1_S 6'd13
`define SEG_G0_L 6'd18
`define SEG_G0_S 6'd14
`define SEG_H_HI 6'd36
`define SEG_H_LO 6'd7

`define SEG_COUNT 40
`define PORT_WIDTH 8
`define WB_ADR_W 8

`endif

// [src/pin_mux_pkg.sv]
`include "pin_mux_cfg.svh"

package pin_mux_pkg;

    typedef struct packed {
        logic pue;
        logic puv;
        logic dde;
        logic ddv;
        logic pve;
        logic pvv;
        logic diee;
        logic diev;
    } ovr_s;

    typedef struct packed {
        logic test_en;
        logic lcd_en;
        logic lcd_lp;
        logic pud;
    } ctrl_s;

    typedef struct packed {
        logic [`PORT_WIDTH-1:0] o;
        logic [`PORT_WIDTH-1:0] oe;
        logic [`PORT_WIDTH-1:0] pull;
    } pin_drive_s;

    typedef logic [`PORT_WIDTH-1:0] byte_t;

endpackage : pin_mux_pkg

// [src/pin_override_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_override_cell
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire ovr_s ovr,
    input wire logic dir_reg,
    input wire logic out_reg,
    input wire logic pud,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic pull_en,
    output logic din
);

    logic pin_o_r, pin_o_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic pull_r, pull_nxt;
    logic din_r, din_nxt;

    // Override value replaces port setting when its enable is set
    always_comb begin
        pin_oe_nxt = ovr.dde ? ovr.ddv : dir_reg;
        pin_o_nxt = ovr.pve ? ovr.pvv : out_reg;
        pull_nxt = ovr.pue ? ovr.puv : (out_reg & ~dir_reg & ~pud);
        din_nxt = (ovr.diee ? ovr.diev : 1'b1) & pin_i;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
            pull_r <= 1'b0;
            din_r <= 1'b0;
        end else if (ce) begin
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
            pull_r <= pull_nxt;
            din_r <= din_nxt;
        end
    end

    assign pin_o = pin_o_r;
    assign pin_oe = pin_oe_r;
    assign pull_en = pull_r;
    assign din = din_r;

endmodule : pin_override_cell

`default_nettype wire

// [src/port_reg_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module port_reg_slave
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire byte_t f_in,
    input wire byte_t g_in,
    input wire byte_t h_in,
    input wire logic [2:0] status,
    output ctrl_s ctrl,
    output byte_t f_dir,
    output byte_t f_out,
    output byte_t g_dir,
    output byte_t g_out,
    output byte_t h_dir,
    output byte_t h_out
);

    logic [3:0] ctrl_r, ctrl_nxt;
    byte_t regs_r [6];
    byte_t regs_nxt [6];
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic take;

    assign take = wb_cyc_i & wb_stb_i & ~ack_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        for (int i = 0; i < 6; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        ack_nxt = take;
        dat_nxt = 32'h0000_0000;
        if (take && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `REG_CTRL: ctrl_nxt = wb_dat_i[3:0];
                `REG_F_DIR: regs_nxt[0] = wb_dat_i[7:0];
                `REG_F_OUT: regs_nxt[1] = wb_dat_i[7:0];
                `REG_G_DIR: regs_nxt[2] = wb_dat_i[7:0];
                `REG_G_OUT: regs_nxt[3] = wb_dat_i[7:0];
                `REG_H_DIR: regs_nxt[4] = wb_dat_i[7:0];
                `REG_H_OUT: regs_nxt[5] = wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (take && !wb_we_i) begin
            case (wb_adr_i)
                `REG_CTRL: dat_nxt = {28'h0000000, ctrl_r};
                `REG_F_DIR: dat_nxt = {24'h000000, regs_r[0]};
                `REG_F_OUT: dat_nxt = {24'h000000, regs_r[1]};
                `REG_G_DIR: dat_nxt = {24'h000000, regs_r[2]};
                `REG_G_OUT: dat_nxt = {24'h000000, regs_r[3]};
                `REG_H_DIR: dat_nxt = {24'h000000, regs_r[4]};
                `REG_H_OUT: dat_nxt = {24'h000000, regs_r[5]};
                `REG_F_IN: dat_nxt = {24'h000000, f_in};
                `REG_G_IN: dat_nxt = {24'h000000, g_in};
                `REG_H_IN: dat_nxt = {24'h000000, h_in};
                `REG_STAT: dat_nxt = {29'h00000000, status};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `CTRL_RST;
            for (int i = 0; i < 6; i++) begin
                regs_r[i] <= 8'h00;
            end
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            for (int i = 0; i < 6; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign ctrl.test_en = ctrl_r[`CTRL_TEST_EN];
    assign ctrl.lcd_en = ctrl_r[`CTRL_LCD_EN];
    assign ctrl.lcd_lp = ctrl_r[`CTRL_LCD_LP];
    assign ctrl.pud = ctrl_r[`CTRL_PUD];
    assign f_dir = regs_r[0];
    assign f_out = regs_r[1];
    assign g_dir = regs_r[2];
    assign g_out = regs_r[3];
    assign h_dir = regs_r[4];
    assign h_out = regs_r[5];

endmodule : port_reg_slave

`default_nettype wire

// [bench/port_fgh_alternate_override_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module port_fgh_alternate_override_sva
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_ack_o,
    input wire byte_t f_pin_i,
    input wire pin_drive_s f_drive,
    input wire byte_t g_pin_i,
    input wire pin_drive_s g_drive,
    input wire pin_drive_s h_drive,
    input wire logic tap_shift_ir,
    input wire logic tap_shift_dr,
    input wire logic tap_serial_out,
    input wire logic test_clock,
    input wire logic test_mode_select,
    input wire logic test_data_in,
    input wire logic reset_pin_disable_fuse,
    input wire logic external_reset_b,
    input wire logic timer_zero_count_input,
    input wire logic [4:0] g_segment_output,
    input wire byte_t h_segment_output
);
    // High when the outputs were updated at the previous edge
    logic live_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            live_r <= 1'b0;
        end else begin
            live_r <= ce;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_test_pins_forced: assert property (live_r && test_clock |->
        f_drive.pull[7:4] == 4'hf && f_drive.oe[7] == 1'b0 && f_drive.oe[5:4] == 2'h0)
        else $error("test pins not overridden");
    a_tdo_enable: assert property (live_r && test_clock |->
        f_drive.oe[6] == $past(tap_shift_ir || tap_shift_dr))
        else $error("test data out enable wrong");
    a_tdo_data: assert property (live_r && test_clock && $past(tap_shift_ir || tap_shift_dr) |->
        f_drive.o[6] == $past(tap_serial_out))
        else $error("test data out value wrong");
    a_test_route: assert property (f_pin_i[4] |->
        test_mode_select == (test_clock ? f_pin_i[5] : 1'b1) &&
        test_data_in == (test_clock ? f_pin_i[7] : 1'b1))
        else $error("test inputs misrouted");
    a_g5_input_only: assert property (live_r |-> g_drive.pull[5] && !g_drive.oe[5])
        else $error("second port bit 5 not input with pull-up");
    a_reset_follow: assert property (live_r && reset_pin_disable_fuse |->
        external_reset_b == $past(g_pin_i[5]))
        else $error("reset input does not follow pin");
    a_reset_disabled: assert property (!$past(reset_pin_disable_fuse) && !reset_pin_disable_fuse
        |-> external_reset_b)
        else $error("reset active with fuse programmed");
    a_timer_zero_in: assert property (live_r && !g_drive.oe[4] |->
        timer_zero_count_input == $past(g_pin_i[4]))
        else $error("timer zero input wrong");
    a_lcd_forces_g: assert property (|g_segment_output |->
        g_drive.pull[4:0] == 5'h00 && g_drive.oe[4:0] == 5'h10)
        else $error("lcd override missing on second port");
    a_lcd_forces_h: assert property (|h_segment_output |->
        h_drive.pull == 8'h00 && h_drive.oe == 8'h00)
        else $error("lcd override missing on third port");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule : port_fgh_alternate_override_sva
bind port_fgh_alternate_override port_fgh_alternate_override_sva u_sva (.clk, .rst_b, .ce,
    .wb_ack_o, .f_pin_i, .f_drive, .g_pin_i, .g_drive, .h_drive, .tap_shift_ir, .tap_shift_dr,
    .tap_serial_out, .test_clock, .test_mode_select, .test_data_in, .reset_pin_disable_fuse,
    .external_reset_b, .timer_zero_count_input, .g_segment_output, .h_segment_output);
`default_nettype wire

// [bench/pin_board.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_board
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire pin_drive_s drive,
    input wire byte_t ext,
    input wire byte_t ext_en,
    output byte_t pin
);
    // Floating pins show a changing pattern, never a held value
    byte_t tgl_r = 8'h55;
    always @(posedge clk) tgl_r <= ~tgl_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive.oe[i]) pin[i] = drive.o[i];
            else if (ext_en[i]) pin[i] = ext[i];
            else if (drive.pull[i]) pin[i] = 1'b1;
            else pin[i] = tgl_r[i];
        end
    end
endmodule : pin_board
`default_nettype wire

// [bench/port_fgh_alternate_override_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
module port_fgh_alternate_override_tb
    import pin_mux_pkg::*;
;
    logic clk, rst_b, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, probe;
    logic tap_shift_ir, tap_shift_dr, tap_serial_out, test_clock, test_mode_select, test_data_in;
    logic reset_pin_disable_fuse, external_reset_b, timer_zero_count_input, timer_one_count_input;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [39:0] segment_drive;
    logic [4:0] g_segment_output;
    byte_t f_pin_i, g_pin_i, h_pin_i, analog_pin_path, pin_change_source, h_segment_output;
    byte_t ext, ext_en, o, oe, pu, en, hin;
    pin_drive_s f_drive, g_drive, h_drive;
    typedef struct {int k; logic [31:0] e;} note_s;
    note_s q[$];
    note_s nt;
    byte_t rg [6];
    int n_mismatch, samples_checked, c, s, i;
    int cl [7] = '{0, 8, 2, 6, 4, 1, 11};
    string nm [8] = '{"rdata", "f_drive", "g_drive", "h_drive", "segs", "ins", "test", "tdo"};
    logic tst, lcd, lp, pud;
    port_fgh_alternate_override u_dut (.clk, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .f_pin_i, .f_drive,
        .analog_pin_path, .g_pin_i, .g_drive, .h_pin_i, .h_drive, .tap_shift_ir, .tap_shift_dr,
        .tap_serial_out, .test_clock, .test_mode_select, .test_data_in, .reset_pin_disable_fuse,
        .external_reset_b, .timer_zero_count_input, .timer_one_count_input, .pin_change_source,
        .segment_drive, .g_segment_output, .h_segment_output);
    pin_board u_board (.clk, .drive(f_drive), .ext, .ext_en, .pin(f_pin_i));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] seen(input int k);
        case (k)
            0: return wb_dat_o;
            1: return 32'(f_drive);
            2: return 32'(g_drive & 24'h3f3f3f);
            3: return 32'(h_drive);
            4: return {19'h0, g_segment_output, h_segment_output};
            5: return {21'h0, pin_change_source, timer_one_count_input, timer_zero_count_input,
                external_reset_b};
            6: return {28'h0, analog_pin_path == f_pin_i, test_clock, test_mode_select,
                test_data_in};
            default: return {31'h0, f_pin_i[6]};
        endcase
    endfunction : seen
    task check(input int k, input logic [31:0] sv, input logic [31:0] ev);
        samples_checked++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm[k], ev, sv);
        end
    endtask : check
    task end_sim();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Compares the oldest note with each read answer or output probe
    always @(negedge clk) begin
        if ((wb_ack_o === 1'b1 && !wb_we_i) || probe) begin
            nt = q.pop_front();
            check(nt.k, seen(nt.k), nt.e);
        end
    end
    task expect_out(input int k, input logic [31:0] e);
        q.push_back('{k, e});
        @(posedge clk);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask : expect_out
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            end_sim();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb
    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back('{0, e});
        wb(1'b0, a, 32'h0);
    endtask : rd
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, probe, tap_shift_ir, tap_shift_dr} = '0;
        {tap_serial_out, wb_adr_i, wb_dat_i, segment_drive, g_pin_i, h_pin_i, ext, ext_en} = '0;
        ce = 1'b1;
        wb_sel_i = 4'hf;
        reset_pin_disable_fuse = 1'b1;
        i = $urandom(85);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(`REG_CTRL, 32'h0);
        wb(1'b1, 8'h3c, 32'hff);
        rd(8'h3c, 32'h0);
        wb(1'b1, `REG_STAT, 32'hff);
        rd(`REG_STAT, 32'h4);
        // Clock enable low must freeze the registered inputs
        @(posedge clk);
        ce <= 1'b0;
        g_pin_i <= 8'h10;
        repeat (3) @(posedge clk);
        expect_out(5, 32'h0);
        ce <= 1'b1;
        g_pin_i <= 8'h00;
        repeat (2) @(posedge clk);
        foreach (cl[j]) begin
            for (s = 0; s < 3; s++) begin
                c = cl[j];
                {pud, lp, lcd, tst} = 4'(c);
                for (i = 0; i < 6; i++) begin
                    rg[i] = 8'($urandom);
                    wb(1'b1, 8'(4 + 4 * i), {24'h0, rg[i]});
                    rd(8'(4 + 4 * i), {24'h0, rg[i]});
                end
                g_pin_i <= 8'($urandom) & 8'h3f;
                h_pin_i <= 8'($urandom);
                segment_drive <= 40'({$urandom, $urandom});
                tap_serial_out <= 1'($urandom);
                reset_pin_disable_fuse <= 1'($urandom);
                {tap_shift_dr, tap_shift_ir} <= 2'(s);
                // Tester moves mode and data with its clock only when the port is enabled
                ext <= 8'($urandom);
                ext_en <= tst ? 8'hb0 : 8'h00;
                wb(1'b1, `REG_CTRL, 32'(c));
                rd(`REG_CTRL, 32'(c));
                repeat (3) @(posedge clk);
                o = rg[1];
                oe = rg[0];
                pu = rg[1] & ~rg[0] & {8{~pud}};
                if (tst) begin
                    o[6] = tap_serial_out;
                    oe[7:4] = {1'b0, s != 0, 2'h0};
                    pu[7:4] = 4'hf;
                end
                expect_out(1, {o, oe, pu});
                o = rg[3] & 8'h1f;
                oe = lcd ? 8'h10 : rg[2] & 8'h1f;
                pu = lcd ? 8'h20 : (rg[3] & ~rg[2] & {8{~pud}} & 8'h1f) | 8'h20;
                expect_out(2, {o, oe, pu});
                oe = lcd ? 8'h00 : rg[4];
                pu = lcd ? 8'h00 : rg[5] & ~rg[4] & {8{~pud}};
                expect_out(3, {rg[5], oe, pu});
                expect_out(4, lcd ? {segment_drive[32], segment_drive[33], segment_drive[4],
                    segment_drive[17], segment_drive[18], segment_drive[36], segment_drive[37],
                    segment_drive[38], segment_drive[39], segment_drive[7], segment_drive[8],
                    segment_drive[9], segment_drive[10]} : 32'h0);
                en = lcd ? (lp ? 8'he0 : 8'hfb) : 8'hff;
                hin = (lcd && lp) ? 8'h00 : h_pin_i;
                expect_out(5, {hin, g_pin_i[3] & en[3], g_pin_i[4] & en[4],
                    reset_pin_disable_fuse ? g_pin_i[5] : 1'b1});
                rd(`REG_G_IN, {24'h0, g_pin_i & en});
                rd(`REG_H_IN, {24'h0, hin});
                expect_out(6, tst ? {1'b1, ext[4], ext[5], ext[7]} : 32'hb);
                if (tst) expect_out(7, s != 0 ? tap_serial_out : 1'b1);
            end
        end
        end_sim();
    end
endmodule : port_fgh_alternate_override_tb
`default_nettype wire
